// *** common/fpc_pkg.sv ***
// Constants, symbol codes and carrier types of the 100 Mb/s coding sublayer
// Function
// - Symbol coding only in 100 Mb/s mode
// - Data nibbles map to fixed 5-bit groups
// - Start delimiter is J 11000 then K 10001
// - End delimiter is T 01101 then R 00111
// - Idle 11111, error 00100, no data meaning
// - Invalid received group sets receive error
// - Idle receiver waits for a zero bit
// - Frame on J at first zeros, assert carrier
// - Next symbol must be K before decoding
// - Unconfirmed JK gives false carrier, back idle
// - Half duplex: collision while sending and receiving
// - Full duplex: collision never asserted
// - Symbols serialised and deserialised on framed boundary
// - First two transmit nibbles replaced by J K
// - Append T R after last transmit nibble
// - Received J K become two 0101 nibbles
// - Received T R never reach the MAC
package fpc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ    = 4'h8;
    localparam logic [3:0] ADDR_MASK   = 4'hC;

    localparam int CTRL_MODE100 = 0;
    localparam int CTRL_FDX     = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    localparam int IRQ_W        = 4;
    localparam int IRQ_RX_ERR   = 0;
    localparam int IRQ_FALSE_CS = 1;
    localparam int IRQ_RX_DONE  = 2;
    localparam int IRQ_TX_DONE  = 3;

    localparam int ST_CARRIER = 0;
    localparam int ST_TX_ACT  = 1;
    localparam int ST_COL     = 2;

    // ------------------------------------------------------------------
    // Symbol codes, bit 4 goes on the line first
    // ------------------------------------------------------------------
    localparam logic [4:0] SYM_I = 5'h1F;
    localparam logic [4:0] SYM_J = 5'h18;
    localparam logic [4:0] SYM_K = 5'h11;
    localparam logic [4:0] SYM_T = 5'h0D;
    localparam logic [4:0] SYM_R = 5'h07;
    localparam logic [4:0] SYM_H = 5'h04;
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [2:0] SYM_BITS  = 3'h5;
    localparam logic [2:0] J_ZERO_AT = 3'h3;

    localparam logic [4:0] ENC_TBL [16] = '{
        5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
    };

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [3:0] nib;
    } fpc_tx_t;

    typedef struct packed {
        logic       dv;
        logic       er;
        logic       stb;
        logic [3:0] nib;
    } fpc_rx_t;

endpackage : fpc_pkg

// *** rtl/fpc_pcs.sv ***
// 100 Mb/s coding sublayer: 4B/5B coding, delimiters, framer, AHB-Lite registers
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module fpc_pcs
    import fpc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    // MAC side
    input  wire fpc_tx_t     mac_tx,
    output logic             mac_tx_ready,
    output fpc_rx_t          mac_rx,
    output logic             mac_col,
    output logic             mac_crs,
    // Serial side, bit clock and data from outside
    input  wire logic        ser_clk,
    input  wire logic        ser_rx_bit,
    output logic             ser_tx_bit
);

    // ------------------------------------------------------------------
    // Code lookup
    // ------------------------------------------------------------------
    function automatic logic [4:0] dec5(input logic [4:0] s);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (ENC_TBL[i] == s) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : dec5

    // ------------------------------------------------------------------
    // Registers on the bus
    // ------------------------------------------------------------------
    logic [1:0]       ctrl_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_ev;
    logic [3:0]       dp_addr_r;
    logic             dp_wr_r;
    logic [31:0]      hrdata_r;

    wire        ap_valid  = hsel & hready & htrans[1];
    wire        ap_read   = ap_valid & ~hwrite;
    wire [3:0]  ap_addr   = haddr[3:0];
    wire        wr_ctrl   = dp_wr_r & (dp_addr_r == ADDR_CTRL);
    wire        wr_mask   = dp_wr_r & (dp_addr_r == ADDR_MASK);
    wire        rd_irq    = ap_read & (ap_addr == ADDR_IRQ);
    wire        mode100   = ctrl_r[CTRL_MODE100];
    wire        fdx       = ctrl_r[CTRL_FDX];

    logic       carrier_r;
    logic       tx_act;
    logic       col_r;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ap_addr)
            ADDR_CTRL:   rd_mux[1:0] = ctrl_r;
            ADDR_STATUS: begin
                rd_mux[ST_CARRIER] = carrier_r;
                rd_mux[ST_TX_ACT]  = tx_act;
                rd_mux[ST_COL]     = col_r;
            end
            ADDR_IRQ:    rd_mux[IRQ_W-1:0] = irq_stat_r;
            ADDR_MASK:   rd_mux[IRQ_W-1:0] = irq_mask_r;
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero wait states: read data is latched in the address phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign irq       = |(irq_stat_r & irq_mask_r);

    // A read of the status clears it, but an event in the same cycle survives
    wire [IRQ_W-1:0] irq_nxt = (irq_stat_r & ~{IRQ_W{rd_irq}}) | irq_ev;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r     <= CTRL_RESET;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            dp_addr_r  <= 4'h0;
            dp_wr_r    <= 1'b0;
            hrdata_r   <= 32'h0000_0000;
        end else begin
            dp_addr_r  <= ap_addr;
            dp_wr_r    <= ap_valid & hwrite;
            if (ap_read) begin
                hrdata_r <= rd_mux;
            end
            if (wr_ctrl) begin
                ctrl_r <= hwdata[1:0];
            end
            if (wr_mask) begin
                irq_mask_r <= hwdata[IRQ_W-1:0];
            end
            irq_stat_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Serial clock and data synchronisers, edge detection
    // ------------------------------------------------------------------
    logic [1:0] sck_sync_r;
    logic [1:0] rxb_sync_r;
    logic       sck_prev_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            sck_sync_r <= 2'b00;
            rxb_sync_r <= 2'b11;
            sck_prev_r <= 1'b0;
        end else begin
            sck_sync_r <= {sck_sync_r[0], ser_clk};
            rxb_sync_r <= {rxb_sync_r[0], ser_rx_bit};
            sck_prev_r <= sck_sync_r[1];
        end
    end

    wire sck_rise = sck_sync_r[1] & ~sck_prev_r;
    wire sck_fall = ~sck_sync_r[1] & sck_prev_r;
    wire rx_bit   = rxb_sync_r[1];

    // ------------------------------------------------------------------
    // Transmit: symbol sequencer and serialiser
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_K, TX_DATA, TX_T, TX_R} fpc_txs_t;

    fpc_txs_t   txs_r;
    fpc_txs_t   txs_nxt;
    logic [4:0] tx_sh_r;
    logic [2:0] tx_cnt_r;
    logic [4:0] tx_sym;
    logic       tx_take;
    logic       tx_done_ev;

    // A new symbol is loaded on the falling edge that ends the old one
    wire tx_load = sck_fall & (tx_cnt_r == SYM_BITS - 3'h1);

    always_comb begin
        txs_nxt    = txs_r;
        tx_sym     = SYM_I;
        tx_take    = 1'b0;
        tx_done_ev = 1'b0;
        unique case (txs_r)
            TX_IDLE: if (mac_tx.valid & mode100) begin
                tx_sym  = SYM_J;
                tx_take = 1'b1;
                txs_nxt = TX_K;
            end
            TX_K: begin
                tx_sym  = SYM_K;
                tx_take = mac_tx.valid;
                txs_nxt = mac_tx.last ? TX_T : TX_DATA;
            end
            TX_DATA: if (mac_tx.valid) begin
                tx_sym  = ENC_TBL[mac_tx.nib];
                tx_take = 1'b1;
                txs_nxt = mac_tx.last ? TX_T : TX_DATA;
            end else begin
                // Underrun closes the frame rather than sending garbage
                tx_sym  = SYM_T;
                txs_nxt = TX_R;
            end
            TX_T: begin
                tx_sym  = SYM_T;
                txs_nxt = TX_R;
            end
            TX_R: begin
                tx_sym     = SYM_R;
                tx_done_ev = 1'b1;
                txs_nxt    = TX_IDLE;
            end
        endcase
    end

    assign mac_tx_ready = tx_load & tx_take;
    assign tx_act       = (txs_r != TX_IDLE);

    always_ff @(posedge clk) begin
        if (rst) begin
            txs_r    <= TX_IDLE;
            tx_sh_r  <= SYM_I;
            tx_cnt_r <= 3'h0;
        end else if (sck_fall) begin
            if (tx_load) begin
                txs_r    <= txs_nxt;
                tx_sh_r  <= tx_sym;
                tx_cnt_r <= 3'h0;
            end else begin
                tx_sh_r  <= {tx_sh_r[3:0], 1'b1};
                tx_cnt_r <= tx_cnt_r + 3'h1;
            end
        end
    end

    assign ser_tx_bit = tx_sh_r[4];

    // ------------------------------------------------------------------
    // Receive: carrier detector, framer and decoder
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {RX_IDLE, RX_J, RX_K, RX_DATA, RX_R} fpc_rxs_t;

    fpc_rxs_t   rxs_r;
    logic [4:0] rx_sh_r;
    logic [2:0] rx_cnt_r;
    logic       pre_pend_r;
    fpc_rx_t    rx_r;

    wire [4:0] rx_sym   = {rx_sh_r[3:0], rx_bit};
    wire       sym_end  = sck_rise & (rx_cnt_r == SYM_BITS - 3'h1);
    wire [4:0] dec      = dec5(rx_sym);
    wire       sym_ctl  = (rx_sym == SYM_T) | (rx_sym == SYM_I);
    wire       in_idle  = (rxs_r == RX_IDLE);
    wire       j_seen   = sym_end & (rxs_r == RX_J);
    wire       k_seen   = sym_end & (rxs_r == RX_K);
    wire       d_seen   = sym_end & (rxs_r == RX_DATA);
    wire       r_seen   = sym_end & (rxs_r == RX_R);
    wire       j_ok     = j_seen & (rx_sym == SYM_J);
    wire       k_ok     = k_seen & (rx_sym == SYM_K);
    wire       false_cs = (j_seen & ~j_ok) | (k_seen & ~k_ok);
    wire       d_bad    = d_seen & ~dec[4] & ~sym_ctl;
    wire       d_end    = d_seen & sym_ctl;
    // A missing R after T is reported as a receive error too
    wire       r_bad    = r_seen & (rx_sym != SYM_R);
    wire       frame_end = d_end | r_seen;

    assign irq_ev[IRQ_RX_ERR]   = d_bad | r_bad;
    assign irq_ev[IRQ_FALSE_CS] = false_cs;
    assign irq_ev[IRQ_RX_DONE]  = r_seen;
    assign irq_ev[IRQ_TX_DONE]  = tx_load & tx_done_ev;

    always_ff @(posedge clk) begin
        if (rst | ~mode100) begin
            rxs_r    <= RX_IDLE;
            rx_sh_r  <= SYM_I;
            rx_cnt_r <= 3'h0;
        end else if (sck_rise) begin
            rx_sh_r  <= rx_sym;
            rx_cnt_r <= sym_end ? 3'h0 : rx_cnt_r + 3'h1;
            unique case (rxs_r)
                RX_IDLE: if (~rx_bit) begin
                    // Two leading ones plus this zero already belong to J
                    rxs_r    <= RX_J;
                    rx_cnt_r <= J_ZERO_AT;
                end
                RX_J:    if (sym_end) begin
                    rxs_r <= j_ok ? RX_K : RX_IDLE;
                end
                RX_K:    if (sym_end) begin
                    rxs_r <= k_ok ? RX_DATA : RX_IDLE;
                end
                RX_DATA: if (sym_end) begin
                    if (rx_sym == SYM_T) begin
                        rxs_r <= RX_R;
                    end else if (rx_sym == SYM_I) begin
                        rxs_r <= RX_IDLE;
                    end
                end
                RX_R:    if (sym_end) begin
                    rxs_r <= RX_IDLE;
                end
            endcase
        end
    end

    // Nibble output: J K become two preamble nibbles, T R produce none
    // The second preamble nibble follows the first on the next clock, long
    // before the next symbol can end, so the two strobes never collide.
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_r       <= '0;
            pre_pend_r <= 1'b0;
            carrier_r  <= 1'b0;
        end else begin
            rx_r.stb   <= 1'b0;
            pre_pend_r <= 1'b0;
            if (j_ok) begin
                carrier_r <= 1'b1;
            end else if (false_cs | frame_end | ~mode100) begin
                carrier_r <= 1'b0;
            end
            if (k_ok | pre_pend_r) begin
                rx_r.stb   <= 1'b1;
                rx_r.dv    <= 1'b1;
                rx_r.er    <= 1'b0;
                rx_r.nib   <= NIB_PREAMBLE;
                pre_pend_r <= k_ok;
            end else if (d_seen & ~sym_ctl) begin
                rx_r.stb <= 1'b1;
                rx_r.er  <= d_bad;
                rx_r.nib <= dec[3:0];
            end else if (frame_end | false_cs | ~mode100) begin
                rx_r.dv  <= 1'b0;
                rx_r.er  <= 1'b0;
            end
        end
    end

    assign mac_rx  = rx_r;
    assign mac_crs = carrier_r;

    // ------------------------------------------------------------------
    // Collision
    // ------------------------------------------------------------------
    // Carrier stands for the whole received frame, from J to the closing
    // symbol, and tx_act from J to T, so their overlap is the time both
    // directions are busy. The flag is registered one clock late; that
    // costs nothing against a frame many hundred clocks long and keeps
    // the output free of glitches from the state decode.
    // Full duplex masks it outright, whatever the traffic.
    always_ff @(posedge clk) begin
        if (rst) begin
            col_r <= 1'b0;
        end else begin
            col_r <= ~fdx & tx_act & carrier_r;
        end
    end

    assign mac_col = col_r;

endmodule : fpc_pcs

// *** verification/fpc_pcs_monitor.sv ***
// Port assertions for the 100 Mb/s coding sublayer
`timescale 1ns/1ns
module fpc_pcs_monitor
    import fpc_pkg::*;
(
    input logic    clk,
    input logic    rst,
    input logic    irq,
    input logic    mac_tx_ready,
    input fpc_rx_t mac_rx,
    input logic    mac_col,
    input logic    mac_crs,
    input logic    ser_tx_bit
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_idle; $fell(rst) |-> ser_tx_bit && !mac_crs && !mac_col && !irq; endproperty
    a_idle: assert property (p_idle) else $error("not idle after reset");
    // One nibble per symbol, and a symbol lasts five link periods
    property p_rdy; mac_tx_ready |=> !mac_tx_ready [*8]; endproperty
    a_rdy: assert property (p_rdy) else $error("nibbles taken too fast");
    // A line bit lasts 12 or 13 clk, so a shorter run is a glitch
    property p_bit; $changed(ser_tx_bit) |=> $stable(ser_tx_bit) [*8]; endproperty
    a_bit: assert property (p_bit) else $error("serial bit too short");
    property p_pre; $rose(mac_rx.dv) |-> ##[0:1] (mac_rx.stb && mac_rx.nib == 4'h5)
        ##1 (mac_rx.stb && mac_rx.nib == 4'h5); endproperty
    a_pre: assert property (p_pre) else $error("no preamble pair");
    property p_er; mac_rx.stb && mac_rx.er |-> mac_rx.nib == 4'h0; endproperty
    a_er: assert property (p_er) else $error("error nibble not zero");
    property p_crs; mac_rx.stb |-> mac_crs && mac_rx.dv; endproperty
    a_crs: assert property (p_crs) else $error("nibble without carrier");
    property p_eos; $fell(mac_rx.dv) |-> !mac_rx.stb [*8]; endproperty
    a_eos: assert property (p_eos) else $error("nibble after end of stream");
    property p_col; mac_col |-> mac_crs || $past(mac_crs); endproperty
    a_col: assert property (p_col) else $error("collision without carrier");
endmodule : fpc_pcs_monitor

bind fpc_pcs fpc_pcs_monitor u_mon (.clk(clk), .rst(rst), .irq(irq),
    .mac_tx_ready(mac_tx_ready), .mac_rx(mac_rx), .mac_col(mac_col), .mac_crs(mac_crs),
    .ser_tx_bit(ser_tx_bit));

// *** verification/fpc_mac_model.sv ***
// MAC partner model: sends queued frames, collects received nibbles
`timescale 1ns/1ns
module fpc_mac_model
    import fpc_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    mac_tx_ready,
    input  wire fpc_rx_t mac_rx,
    output fpc_tx_t      mac_tx
);
    // ----------------------------------------------------------------
    // Queues of {last, nib} and {er, nib}
    // ----------------------------------------------------------------
    logic [4:0] txq [$];
    logic [4:0] rxq [$];
    initial mac_tx = '0;
    task automatic frame(input int n);
        txq.push_back(5'h05);
        txq.push_back(5'h05);
        for (int k = 0; k < n; k++) begin
            txq.push_back({k == n - 1, 4'(k)});
        end
    endtask : frame
    // Held until taken; an idle nibble bus shows junk, not the last value
    always @(posedge clk) begin
        if (mac_tx.valid && mac_tx_ready)
            void'(txq.pop_front());
        if (mac_rx.stb)
            rxq.push_back({mac_rx.er, mac_rx.nib});
        if (txq.size() > 0)
            mac_tx <= {1'h1, txq[0]};
        else
            mac_tx <= {2'h0, ~mac_tx.nib};
    end
endmodule : fpc_mac_model

// *** verification/fpc_pcs_bench.sv ***
// Self-checking bench for the 100 Mb/s coding sublayer
`timescale 1ns/1ns
module fpc_pcs_bench
    import fpc_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals, clocks, bus and line tasks
    // ----------------------------------------------------------------
    localparam logic [4:0] CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic        clk = 1'h0, rst = 1'h1, ser_clk = 1'h0, ser_rx_bit = 1'h1;
    logic        hsel = 1'h0, hwrite = 1'h0, col_seen = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hready, hresp, irq, mac_tx_ready, mac_col, mac_crs, ser_tx_bit;
    logic [4:0]  sh;
    fpc_tx_t     mac_tx;
    fpc_rx_t     mac_rx;
    int          mismatches = 0, n_tests = 0;
    fpc_pcs dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .irq(irq), .mac_tx(mac_tx), .mac_tx_ready(mac_tx_ready),
        .mac_rx(mac_rx), .mac_col(mac_col), .mac_crs(mac_crs), .ser_clk(ser_clk),
        .ser_rx_bit(ser_rx_bit), .ser_tx_bit(ser_tx_bit));
    fpc_mac_model mac (.clk(clk), .mac_tx_ready(mac_tx_ready), .mac_rx(mac_rx), .mac_tx(mac_tx));
    initial forever #5 clk = ~clk;
    // Link clock, 125 ns; only its falling edges avoid clk edges, its rising edges land on them
    initial begin
        #3;
        forever begin
            #62 ser_clk = ~ser_clk;
            #63 ser_clk = ~ser_clk;
        end
    end
    always @(posedge clk) if (mac_col === 1'h1) col_seen <= 1'h1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task automatic rw(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= 32'(a);
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask : rw
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        rw(1'h0, a, 32'h0);
        chk(rd, e);
        chk(32'(hresp), 32'h0);
    endtask : rd_chk
    task automatic rx_sym(input logic [4:0] s);
        for (int b = 4; b >= 0; b--) begin
            @(negedge ser_clk);
            @(posedge clk);
            ser_rx_bit <= s[b];
        end
    endtask : rx_sym
    task automatic rx_frame(input logic [4:0] q [$]);
        rx_sym(5'h18);
        rx_sym(5'h11);
        chk(32'(mac_crs), 32'h1);
        foreach (q[k]) rx_sym(q[k]);
        rx_sym(5'h0D);
        rx_sym(5'h07);
        repeat (3) rx_sym(5'h1F);
    endtask : rx_frame
    task automatic rx_exp(input logic [4:0] e [$]);
        chk(32'(mac.rxq.size()), 32'(e.size()));
        foreach (e[k]) chk(32'(mac.rxq[k]), 32'(e[k]));
        mac.rxq.delete();
    endtask : rx_exp
    task automatic tx_exp(input logic [4:0] e);
        repeat (5) begin
            @(posedge ser_clk);
            sh = {sh[3:0], ser_tx_bit};
        end
        chk(32'(sh), 32'(e));
    endtask : tx_exp
    // Idle line is all ones, so the first time J fills the window is its end
    task automatic hunt_j;
        sh = 5'h1F;
        for (int n = 0; n < 400 && sh !== 5'h18; n++) begin
            @(posedge ser_clk);
            sh = {sh[3:0], ser_tx_bit};
        end
        chk(32'(sh), 32'h18);
    endtask : hunt_j
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_tx;
        logic [4:0] e [$];
        rw(1'h0, ADDR_IRQ, 32'h0);
        mac.frame(16);
        hunt_j;
        rw(1'h0, ADDR_STATUS, 32'h0);
        chk(rd & 32'h2, 32'h2);
        e = '{5'h11};
        foreach (CODE[n]) e.push_back(CODE[n]);
        e = {e, 5'h0D, 5'h07, 5'h1F, 5'h1F};
        foreach (e[n]) tx_exp(e[n]);
        rw(1'h0, ADDR_IRQ, 32'h0);
        chk(rd & 32'h8, 32'h8);
        $display("tx done");
    endtask : t_tx
    task automatic t_rx;
        logic [4:0] q [$];
        logic [4:0] e [$];
        rw(1'h0, ADDR_IRQ, 32'h0);
        e = '{5'h05, 5'h05};
        foreach (CODE[n]) q.push_back(CODE[n]);
        for (int n = 0; n < 16; n++) e.push_back(5'(n));
        rx_frame(q);
        rx_exp(e);
        chk(32'(irq), 32'h0);
        rd_chk(ADDR_IRQ, 32'h4);
        rd_chk(ADDR_IRQ, 32'h0);
        $display("rx done");
    endtask : t_rx
    task automatic t_err;
        rw(1'h1, ADDR_MASK, 32'h1);
        rx_frame('{5'h00, 5'h19, 5'h04, CODE[3]});
        rx_exp('{5'h05, 5'h05, 5'h10, 5'h10, 5'h10, 5'h03});
        chk(32'(irq), 32'h1);
        rw(1'h0, ADDR_IRQ, 32'h0);
        chk(rd & 32'h1, 32'h1);
        chk(32'(irq), 32'h0);
        rw(1'h1, ADDR_MASK, 32'h0);
        $display("err done");
    endtask : t_err
    task automatic t_false;
        logic [4:0] a [2] = '{5'h18, 5'h19};
        logic [4:0] b [2] = '{5'h0B, 5'h1F};
        for (int n = 0; n < 2; n++) begin
            rw(1'h0, ADDR_IRQ, 32'h0);
            rx_sym(a[n]);
            rx_sym(b[n]);
            repeat (3) rx_sym(5'h1F);
            chk(32'(mac.rxq.size()), 32'h0);
            chk(32'(mac_crs), 32'h0);
            rw(1'h0, ADDR_IRQ, 32'h0);
            chk(rd & 32'h2, 32'h2);
        end
        $display("false done");
    endtask : t_false
    task automatic t_col;
        for (int f = 0; f < 2; f++) begin
            rw(1'h1, ADDR_CTRL, 32'(f * 2 + 1));
            col_seen = 1'h0;
            mac.frame(8);
            rx_frame('{CODE[1], CODE[2], CODE[3], CODE[4], CODE[5], CODE[6], CODE[7]});
            if (f == 0)
                chk(32'(col_seen), 32'h1);
            else
                chk(32'(col_seen), 32'h0);
            mac.rxq.delete();
        end
        rw(1'h1, ADDR_CTRL, 32'h1);
        $display("col done");
    endtask : t_col
    // With coding off the frame must wait whole in the MAC
    task automatic t_mode;
        rw(1'h1, ADDR_CTRL, 32'h0);
        mac.frame(2);
        repeat (400) @(posedge clk);
        chk(32'(mac.txq.size()), 32'h4);
        chk(32'(ser_tx_bit), 32'h1);
        rd_chk(ADDR_STATUS, 32'h0);
        rw(1'h1, ADDR_CTRL, 32'h1);
        hunt_j;
        repeat (60) @(posedge ser_clk);
        chk(32'(mac.txq.size()), 32'h0);
        $display("mode done");
    endtask : t_mode
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        rd_chk(ADDR_CTRL, 32'h1);
        rd_chk(ADDR_MASK, 32'h0);
        t_tx;
        t_rx;
        t_err;
        t_false;
        t_col;
        t_mode;
        finish_test;
    end
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        finish_test;
    end
endmodule : fpc_pcs_bench
